/* File: verilog/perf_event_counter_select.sv */
// event selection, qualification and counting for one core counter
//
// What this block does
// - code 30H counts second level refusal cycles
// - code 32H counts cycles with no second-level request
// - 3C/00H counts core cycles while unhalted
// - 3C/01H counts bus cycles while unhalted
// - 3C/02H counts bus cycles, sibling halted, self running
// - 4FH/00H counts first level prefetch requests
// - refused prefetch requests are reissued, not dropped
// - 78H/01H counts sibling snoops of data cache that miss or write a read-only line
// - snoops use store port, stalling stores
// - 7DH/00H counts bus cycles with nothing outstanding
// - 77H/00H counts clean, hit, hit-modified responses
// - dispatch event, invert, threshold 1: idle cycles
// - dispatch event, threshold 1: cycles dispatching
// - core active when unhalted or being snooped
// - unhalted cycle events stop while halted, even snooped
`timescale 1ns/1ps
`default_nettype none
`include "pec_defs.svh"
module perf_event_counter_select #(
    parameter int         CNT_W     = 32,   // counter width, at most 32
    parameter int         BUS_RATIO = 4,    // core cycles per bus cycle
    parameter logic [7:0] UOP_CODE  = 8'ha0 // micro-op dispatch event code
) (
    input  wire logic                   i_clk,           // core clock
    input  wire logic                   i_rst,           // async reset
    input  wire logic [3:0]             i_addr,          // register address
    input  wire logic [31:0]            i_wdata,         // write data
    input  wire logic                   i_wr,            // write strobe
    input  wire logic                   i_rd,            // read strobe
    output logic      [31:0]            o_rdata,         // read data
    input  wire logic                   i_core_halted,   // core in halt
    input  wire logic                   i_snooped,       // core snooped
    input  wire logic                   i_sibling_halted,// other core halted
    input  wire logic                   i_l2_refuse,     // l2 refuses access
    input  wire logic                   i_l1_req,        // l1 request to l2
    input  wire logic                   i_pf_want,       // l1 wants prefetch
    output logic                        o_pf_ready,      // prefetch accepted
    output logic                        o_pf_req,        // prefetch to l2
    input  wire logic                   i_sib_snoop,     // sibling snoop
    input  wire logic                   i_sib_miss,      // line absent there
    input  wire logic                   i_sib_write_ro,  // write to ro line
    input  wire logic                   i_store_req,     // store wants port
    output logic                        o_store_grant,   // store uses port
    output logic                        o_store_snoop,   // snoop uses port
    input  wire logic                   i_bus_pending,   // bus txn waiting
    input  wire pec_pkg::snoop_resp_t   i_snoop_resp,    // ext snoop answer
    input  wire logic [`PEC_UOP_W-1:0]  i_uops,          // uops dispatched
    output logic                        o_core_active,   // core is active
    output logic                        o_bus_tick       // bus clock enable
);
    import pec_pkg::*;

    typedef struct packed {
        logic [7:0]       code;
        logic [7:0]       umask;
        logic             enable;
        logic             invert;
        logic [7:0]       thresh;
        logic [CNT_W-1:0] count;
        logic [31:0]      rdata;
    } pec_s;

    pec_s s_q;
    pec_s s_d;

    logic        pf_issue_w;
    logic        pf_new_w;
    logic        active_w;
    logic        unhalted_w;
    logic        snoop_use_w;
    logic        resp_w;
    event_kind_e kind_w;

    // map the programmed code and unit mask onto one condition
    function automatic event_kind_e decode(input logic [7:0] code,
                                           input logic [7:0] umask,
                                           input logic [7:0] uop_code);
        event_kind_e k;
        k = EV_NONE;
        if (code == uop_code)
            k = EV_UOP_DISP;
        else
        begin
            case (code)
                `PEC_EV_REFUSE:  k = EV_REFUSE;
                `PEC_EV_L2_IDLE: k = EV_L2_IDLE;
                `PEC_EV_UNHALTED:
                begin
                    case (umask)
                        `PEC_UM_00: k = EV_CORE_CYC;
                        `PEC_UM_01: k = EV_REF_CYC;
                        `PEC_UM_02: k = EV_SERIAL_CYC;
                        default:    k = EV_NONE;
                    endcase
                end
                `PEC_EV_PF_REQ:
                    k = (umask == `PEC_UM_00) ? EV_PF_REQ : EV_NONE;
                `PEC_EV_SIB_SNOOP:
                    k = (umask == `PEC_UM_01) ? EV_SIB_SNOOP : EV_NONE;
                `PEC_EV_BUS_IDLE:
                    k = (umask == `PEC_UM_00) ? EV_BUS_IDLE : EV_NONE;
                `PEC_EV_BUS_SNOOP:
                    k = (umask == `PEC_UM_00) ? EV_BUS_SNOOP : EV_NONE;
                default: k = EV_NONE;
            endcase
        end
        return k;
    endfunction : decode

    bus_tick_divider #(
        .RATIO (BUS_RATIO)
    ) u_div (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (o_bus_tick)
    );

    prefetch_reissue u_pf (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_want   (i_pf_want),
        .i_refuse (i_l2_refuse),
        .o_ready  (o_pf_ready),
        .o_issue  (pf_issue_w),
        .o_new    (pf_new_w)
    );

    // a snoop keeps the core active even in halt, but the unhalted
    // cycle events look at halt alone
    assign unhalted_w    = ~i_core_halted;
    assign active_w      = unhalted_w | i_snooped;
    assign o_core_active = active_w;
    assign o_pf_req      = pf_issue_w;
    assign kind_w        = decode(s_q.code, s_q.umask, UOP_CODE);

    // snoops win the store port; the stalled store waits a cycle,
    // which is where the extra store latency comes from
    assign snoop_use_w   = i_sib_snoop;
    assign o_store_snoop = snoop_use_w;
    assign o_store_grant = i_store_req & ~snoop_use_w;

    // snoop answers that count; a missing response is not one
    assign resp_w = (i_snoop_resp == `PEC_RESP_CLEAN) ||
                    (i_snoop_resp == `PEC_RESP_HIT)   ||
                    (i_snoop_resp == `PEC_RESP_HIT_MOD);

    // per-cycle amount, qualification, counting and register access
    always_comb
    begin
        logic [`PEC_UOP_W-1:0] amount;
        logic [`PEC_UOP_W-1:0] step;
        logic                  meets;
        amount = '0;
        step   = '0;
        meets  = 1'b0;
        s_d    = s_q;
        case (kind_w)
            EV_REFUSE:
                amount = {2'b00, i_l2_refuse & active_w};
            EV_L2_IDLE:
                amount = {2'b00, active_w & ~i_l1_req & ~pf_issue_w};
            EV_CORE_CYC:
                amount = {2'b00, unhalted_w};
            EV_REF_CYC:
                amount = {2'b00, unhalted_w & o_bus_tick};
            EV_SERIAL_CYC:
                amount = {2'b00, unhalted_w & i_sibling_halted &
                          o_bus_tick};
            EV_PF_REQ:
                amount = {2'b00, pf_new_w};
            EV_SIB_SNOOP:
                amount = {2'b00, i_sib_snoop &
                          (i_sib_miss | i_sib_write_ro)};
            EV_BUS_IDLE:
                amount = {2'b00, active_w & o_bus_tick &
                          ~i_bus_pending};
            EV_BUS_SNOOP:
                amount = {2'b00, resp_w};
            EV_UOP_DISP:
                amount = active_w ? i_uops : '0;
            default:
                amount = '0;
        endcase
        // a threshold turns an amount into a yes/no per cycle
        if (s_q.thresh == 8'h00)
            step = amount;
        else
        begin
            meets = ({5'b00000, amount} >= s_q.thresh);
            step  = {2'b00, meets ^ s_q.invert};
        end
        // invert must not let the unhalted events run in halt
        if ((kind_w == EV_CORE_CYC || kind_w == EV_REF_CYC ||
             kind_w == EV_SERIAL_CYC) && i_core_halted)
            step = '0;
        if (s_q.enable && kind_w != EV_NONE)
            s_d.count = s_q.count + CNT_W'(step);
        // a software write to the counter wins over counting
        if (i_wr)
        begin
            case (i_addr)
                `PEC_OFF_SEL:
                begin
                    s_d.code   = i_wdata[`PEC_SEL_CODE_LSB +: 8];
                    s_d.umask  = i_wdata[`PEC_SEL_UMASK_LSB +: 8];
                    s_d.enable = i_wdata[`PEC_SEL_EN_BIT];
                    s_d.invert = i_wdata[`PEC_SEL_INVERT_BIT];
                    s_d.thresh = i_wdata[`PEC_SEL_THR_LSB +: 8];
                end
                `PEC_OFF_CNT: s_d.count = i_wdata[CNT_W-1:0];
                default: ;
            endcase
        end
        // read data stand for one cycle only, zero otherwise
        s_d.rdata = 32'h0000_0000;
        if (i_rd)
        begin
            case (i_addr)
                `PEC_OFF_SEL:
                begin
                    s_d.rdata[`PEC_SEL_CODE_LSB +: 8]  = s_q.code;
                    s_d.rdata[`PEC_SEL_UMASK_LSB +: 8] = s_q.umask;
                    s_d.rdata[`PEC_SEL_EN_BIT]         = s_q.enable;
                    s_d.rdata[`PEC_SEL_INVERT_BIT]     = s_q.invert;
                    s_d.rdata[`PEC_SEL_THR_LSB +: 8]   = s_q.thresh;
                end
                `PEC_OFF_CNT:    s_d.rdata = 32'(s_q.count);
                `PEC_OFF_STATUS: s_d.rdata = {28'h0000000, ~o_pf_ready,
                                              i_sibling_halted,
                                              i_core_halted, active_w};
                default:         s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // all control state clears on reset
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q        <= '0;
            s_q.code   <= `PEC_RST_CODE;
            s_q.umask  <= `PEC_RST_UMASK;
            s_q.thresh <= `PEC_RST_THR;
        end
        else
            s_q <= s_d;
    end

    assign o_rdata = s_q.rdata;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // counting is undisturbed when no register write lands this cycle
    logic free_w;
    logic raw_w;
    assign free_w = s_q.enable && !i_wr;
    assign raw_w  = free_w && (s_q.thresh == 8'h00);

    a_refuse_counts: assert property (
        raw_w && kind_w == EV_REFUSE && i_l2_refuse && active_w
        |=> s_q.count == $past(s_q.count) + 1)
        else $error("refusal cycle not counted");

    a_l2_idle_skip: assert property (
        raw_w && kind_w == EV_L2_IDLE && (i_l1_req || pf_issue_w)
        |=> $stable(s_q.count))
        else $error("l2 idle counted while a request went out");

    a_core_cycles: assert property (
        raw_w && kind_w == EV_CORE_CYC && !i_core_halted
        |=> s_q.count == $past(s_q.count) + 1)
        else $error("unhalted core cycle not counted");

    a_ref_on_tick: assert property (
        raw_w && kind_w == EV_REF_CYC && !o_bus_tick
        |=> $stable(s_q.count))
        else $error("reference cycles advanced off a bus tick");

    a_serial_needs: assert property (
        raw_w && kind_w == EV_SERIAL_CYC && o_bus_tick &&
        !i_core_halted && i_sibling_halted
        |=> s_q.count == $past(s_q.count) + 1)
        else $error("serial execution bus cycle not counted");

    a_prefetch_once: assert property (
        raw_w && kind_w == EV_PF_REQ && pf_issue_w && !pf_new_w
        |=> $stable(s_q.count))
        else $error("reissued prefetch counted twice");

    a_sib_snoop: assert property (
        raw_w && kind_w == EV_SIB_SNOOP && i_sib_snoop && i_sib_miss
        |=> s_q.count == $past(s_q.count) + 1)
        else $error("sibling snoop not counted");

    a_store_yields: assert property (
        i_store_req && i_sib_snoop |-> !o_store_grant && o_store_snoop)
        else $error("store took the port during a snoop");

    a_bus_idle: assert property (
        raw_w && kind_w == EV_BUS_IDLE && i_bus_pending
        |=> $stable(s_q.count))
        else $error("bus idle counted with a transaction waiting");

    a_snoop_resp: assert property (
        raw_w && kind_w == EV_BUS_SNOOP &&
        i_snoop_resp == `PEC_RESP_HIT_MOD
        |=> s_q.count == $past(s_q.count) + 1)
        else $error("hit-modified response not counted");

    a_uop_none: assert property (
        free_w && kind_w == EV_UOP_DISP && s_q.invert &&
        s_q.thresh == 8'h01 && active_w && i_uops == '0
        |=> s_q.count == $past(s_q.count) + 1)
        else $error("cycle without dispatch not counted");

    a_uop_some: assert property (
        free_w && kind_w == EV_UOP_DISP && !s_q.invert &&
        s_q.thresh == 8'h01 && active_w && i_uops != 3'd0
        |=> s_q.count == $past(s_q.count) + 1)
        else $error("dispatch cycle did not add exactly one");

    a_active_snoop: assert property (
        i_core_halted && i_snooped |-> o_core_active)
        else $error("snooped halted core not active");

    a_halt_freezes: assert property (
        free_w && i_core_halted && (kind_w == EV_CORE_CYC ||
        kind_w == EV_REF_CYC || kind_w == EV_SERIAL_CYC)
        |=> $stable(s_q.count))
        else $error("unhalted event advanced in halt");

    a_thresh_below: assert property (
        free_w && kind_w == EV_UOP_DISP && !s_q.invert &&
        s_q.thresh > 8'h00 && {5'b00000, i_uops} < s_q.thresh
        |=> $stable(s_q.count))
        else $error("count below threshold still added");

    a_read_once: assert property (
        i_rd ##1 !i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data held past its cycle");

    c_prefetch_retry: cover property (
        pf_new_w && i_l2_refuse ##1 pf_issue_w && !i_l2_refuse);
    c_snoop_stall: cover property (i_store_req && i_sib_snoop);
    c_serial_count: cover property (
        kind_w == EV_SERIAL_CYC && s_q.enable && o_bus_tick &&
        i_sibling_halted && !i_core_halted);
    c_uop_inverted: cover property (
        kind_w == EV_UOP_DISP && s_q.invert && s_q.thresh == 8'h01);
endmodule : perf_event_counter_select
`default_nettype wire

/* File: verilog/pec_defs.svh */
// constants for the performance event selection block
`ifndef PEC_DEFS_SVH
`define PEC_DEFS_SVH

// register byte addresses
`define PEC_OFF_SEL       4'h0
`define PEC_OFF_CNT       4'h4
`define PEC_OFF_STATUS    4'h8

// event select register field positions
`define PEC_SEL_CODE_LSB  0
`define PEC_SEL_UMASK_LSB 8
`define PEC_SEL_EN_BIT    22
`define PEC_SEL_INVERT_BIT 23
`define PEC_SEL_THR_LSB   24

// reset values
`define PEC_RST_CODE      8'h00
`define PEC_RST_UMASK     8'h00
`define PEC_RST_THR       8'h00

// event codes and unit masks
`define PEC_EV_REFUSE     8'h30
`define PEC_EV_L2_IDLE    8'h32
`define PEC_EV_UNHALTED   8'h3c
`define PEC_EV_PF_REQ     8'h4f
`define PEC_EV_BUS_SNOOP  8'h77
`define PEC_EV_SIB_SNOOP  8'h78
`define PEC_EV_BUS_IDLE   8'h7d
`define PEC_UM_00         8'h00
`define PEC_UM_01         8'h01
`define PEC_UM_02         8'h02

// external snoop response codes
`define PEC_RESP_NONE     2'h0
`define PEC_RESP_CLEAN    2'h1
`define PEC_RESP_HIT      2'h2
`define PEC_RESP_HIT_MOD  2'h3

// width of the per-cycle dispatched micro-op count
`define PEC_UOP_W         3

`endif

/* File: verilog/pec_pkg.sv */
// types shared by the performance event selection block
package pec_pkg;
    // which condition the selection registers currently pick
    typedef enum logic [3:0] {
        EV_NONE,
        EV_REFUSE,
        EV_L2_IDLE,
        EV_CORE_CYC,
        EV_REF_CYC,
        EV_SERIAL_CYC,
        EV_PF_REQ,
        EV_SIB_SNOOP,
        EV_BUS_IDLE,
        EV_BUS_SNOOP,
        EV_UOP_DISP
    } event_kind_e;

    // prefetch request sequencer
    typedef enum logic {
        PF_IDLE,
        PF_RETRY
    } pf_state_e;

    typedef logic [1:0] snoop_resp_t;
endpackage : pec_pkg

/* File: verilog/bus_tick_divider.sv */
// divider that gives a one-cycle bus clock enable from the core clock
`timescale 1ns/1ps
`default_nettype none
module bus_tick_divider #(
    parameter int RATIO = 4
) (
    input  wire logic i_clk,  // core clock
    input  wire logic i_rst,  // async reset, high
    output logic      o_tick  // one pulse per bus clock
);
    import pec_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
    } div_s;

    localparam logic [7:0] LAST = 8'(RATIO - 1);

    div_s s_q;
    div_s s_d;

    // wrap at the ratio so the tick period is exactly RATIO cycles
    always_comb
    begin
        s_d = s_q;
        if (s_q.cnt == LAST)
            s_d.cnt = 8'h00;
        else
            s_d.cnt = s_q.cnt + 8'h01;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_tick = (s_q.cnt == LAST);
endmodule : bus_tick_divider
`default_nettype wire

/* File: verilog/dcu_prefetch_retry.sv */
// sequencer that re-issues refused first-level prefetch requests
`timescale 1ns/1ps
`default_nettype none
module prefetch_reissue (
    input  wire logic i_clk,     // core clock
    input  wire logic i_rst,     // async reset, high
    input  wire logic i_want,    // data cache wants a line prefetched
    input  wire logic i_refuse,  // second level cache busy this cycle
    output logic      o_ready,   // ready to take a new want this cycle
    output logic      o_issue,   // request presented to second level
    output logic      o_new      // first attempt of a request
);
    import pec_pkg::*;

    typedef struct packed {
        pf_state_e st;
    } pf_s;

    pf_s s_q;
    pf_s s_d;

    // one request in flight; later wants wait on o_ready
    assign o_ready = (s_q.st == PF_IDLE);
    assign o_new   = o_ready & i_want;
    assign o_issue = o_new | (s_q.st == PF_RETRY);

    // a refused request stays pending and goes out again next cycle
    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            PF_IDLE:  s_d.st = (o_new & i_refuse) ? PF_RETRY : PF_IDLE;
            PF_RETRY: s_d.st = i_refuse ? PF_RETRY : PF_IDLE;
            default:  s_d.st = PF_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            s_q <= '{st: PF_IDLE};
        else
            s_q <= s_d;
    end

    a_refused_reissued: assert property (@(posedge i_clk) disable iff (i_rst)
        o_issue && i_refuse |=> o_issue && !o_new)
        else $error("refused prefetch was dropped");
endmodule : prefetch_reissue
`default_nettype wire

/* File: verif/tb_perf_event_counter_select.sv */
// self-checking bench for the performance event selection block
`timescale 1ns/1ps
`default_nettype none
`include "pec_defs.svh"
module tb_perf_event_counter_select;
    import pec_pkg::*;
    localparam int         R   = 2;     // short bus ratio gives a bus tick every other cycle
    localparam logic [7:0] UOP = 8'ha0;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, r, exp_cnt;
    logic        i_core_halted = 1'b0, i_snooped = 1'b0;
    logic        i_sibling_halted = 1'b0, i_l2_refuse = 1'b0;
    logic        i_l1_req = 1'b0, i_pf_want = 1'b0, i_sib_snoop = 1'b0;
    logic        i_sib_miss = 1'b0, i_sib_write_ro = 1'b0;
    logic        i_store_req = 1'b0, i_bus_pending = 1'b0;
    snoop_resp_t i_snoop_resp = 2'h0;
    logic [2:0]  i_uops = 3'h0;
    logic        o_pf_ready, o_pf_req, o_store_grant, o_store_snoop;
    logic        o_core_active, o_bus_tick, rnd_on = 1'b0;
    logic [7:0]  sel_code, sel_um, sel_thr;
    logic        sel_en, sel_inv, retry;
    int          tcnt, err_count = 0, comparisons = 0;
    integer      seed = 32'hee44;
    wire active_m = !i_core_halted || i_snooped;
    wire tick_m   = tcnt == R - 1;
    wire pf_req_m = retry || i_pf_want;
    wire pf_new_m = i_pf_want && !retry;

    perf_event_counter_select #(.CNT_W(32), .BUS_RATIO(R), .UOP_CODE(UOP))
    uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_core_halted(i_core_halted), .i_snooped(i_snooped),
        .i_sibling_halted(i_sibling_halted), .i_l2_refuse(i_l2_refuse),
        .i_l1_req(i_l1_req), .i_pf_want(i_pf_want),
        .o_pf_ready(o_pf_ready), .o_pf_req(o_pf_req),
        .i_sib_snoop(i_sib_snoop), .i_sib_miss(i_sib_miss),
        .i_sib_write_ro(i_sib_write_ro), .i_store_req(i_store_req),
        .o_store_grant(o_store_grant), .o_store_snoop(o_store_snoop),
        .i_bus_pending(i_bus_pending), .i_snoop_resp(i_snoop_resp),
        .i_uops(i_uops), .o_core_active(o_core_active),
        .o_bus_tick(o_bus_tick));

    always #4 i_clk = ~i_clk;

    // per-cycle increment the counter should see for the current inputs
    function automatic logic [31:0] step_of();
        logic [3:0] amt;
        logic       ok;
        amt = 4'h0;
        ok = 1'b1;
        case (sel_code)
            `PEC_EV_REFUSE:    amt = 4'(i_l2_refuse && active_m);
            `PEC_EV_L2_IDLE:   amt = 4'(active_m && !i_l1_req && !pf_req_m);
            `PEC_EV_UNHALTED:
            begin
                ok = sel_um <= 8'h02 && !i_core_halted;
                amt = 4'(sel_um == 8'h00 || (tick_m &&
                      (sel_um == 8'h01 || i_sibling_halted)));
            end
            `PEC_EV_PF_REQ:    {ok, amt} = {sel_um == 8'h00, 3'h0, pf_new_m};
            `PEC_EV_SIB_SNOOP: {ok, amt} = {sel_um == 8'h01, 3'h0,
                                   i_sib_snoop && (i_sib_miss || i_sib_write_ro)};
            `PEC_EV_BUS_IDLE:  {ok, amt} = {sel_um == 8'h00, 3'h0,
                                   active_m && tick_m && !i_bus_pending};
            `PEC_EV_BUS_SNOOP: {ok, amt} = {sel_um == 8'h00, 3'h0,
                                   i_snoop_resp != 2'h0};
            UOP:               amt = active_m ? {1'b0, i_uops} : 4'h0;
            default:           ok = 1'b0;
        endcase
        if (!ok)
            return 32'h0;
        if (sel_thr == 8'h00)
            return 32'(amt);
        return 32'((8'(amt) >= sel_thr) ^ sel_inv);
    endfunction : step_of

    // reference state follows the bus and the inputs edge by edge
    always @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            {sel_thr, sel_inv, sel_en, sel_um, sel_code} <= 26'h0;
            exp_cnt <= 32'h0;
            retry <= 1'b0;
            tcnt <= 0;
        end
        else
        begin
            if (i_wr && i_addr == `PEC_OFF_CNT)
                exp_cnt <= i_wdata;
            else if (sel_en)
                exp_cnt <= exp_cnt + step_of();
            if (i_wr && i_addr == `PEC_OFF_SEL)
                {sel_thr, sel_inv, sel_en, sel_um, sel_code} <=
                    {i_wdata[31:22], i_wdata[15:0]};
            retry <= pf_req_m && i_l2_refuse;
            tcnt <= (tcnt == R - 1) ? 0 : tcnt + 1;
        end

    // random activity; a held prefetch want is kept until taken
    always @(posedge i_clk)
        if (rnd_on)
        begin
            r = $random(seed);
            {i_snooped, i_sibling_halted, i_l2_refuse, i_l1_req, i_sib_snoop,
             i_sib_miss, i_sib_write_ro, i_store_req, i_bus_pending,
             i_snoop_resp, i_uops} <= r[13:0];
            i_core_halted <= r[14] & r[15];
            if (!i_pf_want || !retry)
                i_pf_want <= r[16];
        end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // combinational outputs looked at mid-cycle, once inputs have settled
    always @(negedge i_clk)
        if (!i_rst)
        begin
            check(32'(o_core_active), 32'(active_m));
            check(32'({o_pf_req, o_pf_ready}), 32'({pf_req_m, !retry}));
            check(32'({o_store_grant, o_store_snoop}),
                  32'({i_store_req && !i_sib_snoop, i_sib_snoop}));
            check(32'(o_bus_tick), 32'(tick_m));
        end

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : bus_wr

    // read data stand only in the cycle after the strobe, then return to 0
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata, e);
        @(negedge i_clk);
        check(o_rdata, 32'h0);
    endtask : bus_rd

    // preload, count under random activity, stop, read back the total
    task automatic run_case(input logic [7:0] c, input logic [7:0] u,
                            input logic v, input logic [7:0] t);
        bus_wr(`PEC_OFF_CNT, 32'($random(seed)));
        bus_wr(`PEC_OFF_SEL, {t, v, 1'b1, 6'h0, u, c});
        @(negedge i_clk) rnd_on = 1'b1;
        repeat (200) @(posedge i_clk);
        @(negedge i_clk) rnd_on = 1'b0;
        bus_wr(`PEC_OFF_SEL, {t, v, 1'b0, 6'h0, u, c});
        @(negedge i_clk);
        bus_rd(`PEC_OFF_CNT, exp_cnt);
        $display("test done: code %h umask %h count %h", c, u, exp_cnt);
    endtask : run_case

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        bus_rd(`PEC_OFF_SEL, 32'h0);
        bus_rd(`PEC_OFF_CNT, 32'h0);
        bus_wr(`PEC_OFF_SEL, 32'hffffffff);
        bus_wr(4'hc, 32'h12345678);        // unmapped write is dropped
        bus_rd(`PEC_OFF_SEL, 32'hffc0ffff);
        bus_rd(4'hc, 32'h0);
        @(posedge i_clk) {i_core_halted, i_snooped, i_sibling_halted} <= 3'b111;
        bus_rd(`PEC_OFF_STATUS, 32'h7);
        run_case(8'h30, 8'h00, 1'b0, 8'h00);
        run_case(8'h32, 8'h00, 1'b0, 8'h00);
        run_case(8'h3c, 8'h00, 1'b0, 8'h00);
        run_case(8'h3c, 8'h01, 1'b0, 8'h00);
        run_case(8'h3c, 8'h02, 1'b0, 8'h00);
        run_case(8'h3c, 8'h00, 1'b1, 8'h01);
        run_case(8'h3c, 8'h03, 1'b0, 8'h00);
        run_case(8'h4f, 8'h00, 1'b0, 8'h00);
        run_case(8'h78, 8'h01, 1'b0, 8'h00);
        run_case(8'h7d, 8'h00, 1'b0, 8'h00);
        run_case(8'h77, 8'h00, 1'b0, 8'h00);
        run_case(UOP, 8'h00, 1'b1, 8'h01);
        run_case(UOP, 8'h00, 1'b0, 8'h01);
        run_case(UOP, 8'h00, 1'b1, 8'h00);
        run_case(UOP, 8'h00, 1'b1, 8'h03);
        run_case(UOP, 8'h00, 1'b0, 8'h07);
        final_report();
    end

    // roughly three times the expected run length before giving up
    initial
    begin
        repeat (10000) @(posedge i_clk);
        err_count++;
        $display("watchdog expired at %0t", $time);
        final_report();
    end
endmodule : tb_perf_event_counter_select
`default_nettype wire
